/* File: hw/nau_pkg.sv */
// package for the nibble arithmetic unit: opcodes, widths, reset values
// assumes a single core clock and an instruction sequencer feeding one opcode per strobe
package nau_pkg;

  // ----------------------------------------
  // widths and reset values
  // ----------------------------------------
  localparam int NAU_DATA_W = 4;
  localparam logic [3:0] NAU_ACC_RESET = 4'h0;
  localparam logic NAU_CARRY_RESET = 1'b0;
  localparam logic [3:0] NAU_TEN = 4'hA;

  // ----------------------------------------
  // opcodes
  // ----------------------------------------
  localparam logic [7:0] NAU_OP_SUM_WITH_CARRY_SKIP = 8'h30;
  localparam logic [7:0] NAU_OP_SUM = 8'h31;
  localparam logic [7:0] NAU_OP_PLUS_TEN = 8'h4A;
  localparam logic [3:0] NAU_OP_IMMEDIATE_SUM_SKIP_HI = 4'h5;
  localparam logic [7:0] NAU_OP_INVERTED_ACC_CARRY_SUM = 8'h10;
  localparam logic [7:0] NAU_OP_ZERO_ACC = 8'h00;
  localparam logic [7:0] NAU_OP_INVERT = 8'h40;
  localparam logic [7:0] NAU_OP_NOP = 8'h44;
  localparam logic [7:0] NAU_OP_CARRY_ZERO = 8'h32;
  localparam logic [7:0] NAU_OP_CARRY_ONE = 8'h22;
  localparam logic [7:0] NAU_OP_XOR = 8'h02;

  // request from the sequencer
  typedef struct packed {
    logic valid;
    logic [7:0] opcode;
  } nau_req_type;

  // result towards the sequencer
  typedef struct packed {
    logic done;
    logic skip;
  } nau_resp_type;

endpackage

/* File: hw/nau_unit.sv */
// nibble arithmetic unit: accumulator, carry, skip reporting
// assumes the sequencer presents one opcode per valid cycle and the data memory
// returns the nibble addressed by the pointer combinationally on mem_data
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Opcode 30 adds accumulator, carry and memory, stores carry-out and skips on carry.
// - Opcode 31 adds memory to the accumulator, carry untouched, no skip.
// - Opcode 4A adds ten to the accumulator, carry untouched, no skip.
// - Opcodes 51 to 5F add the immediate and skip on carry; 50 is not this operation.
// - Opcode 10 adds the inverted accumulator, memory and carry, stores carry, skips on carry.
// - Opcode 00 clears the accumulator with no carry change and no skip.
// - Opcode 40 inverts the accumulator with no carry change and no skip.
// - Opcode 44 changes nothing and never skips.
// - Opcode 32 clears carry and opcode 22 sets it, neither skips.
// - Opcode 02 exclusive-ORs memory into the accumulator, carry kept, no skip.
// - The accumulator is a 4-bit register and carry a 1-bit register.
// - The memory operand is the nibble addressed by row and digit pointers.
module nau_unit
  import nau_pkg::*;
#(
  parameter int ROW_W = 2
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire nau_req_type req,
  input wire logic [ROW_W-1:0] ram_row_pointer,
  input wire logic [3:0] ram_digit_pointer,
  input wire logic [3:0] mem_data,
  output logic [ROW_W+3:0] mem_addr,
  output logic [3:0] acc,
  output logic carry,
  output nau_resp_type resp
);

  // ----------------------------------------
  // combinational datapath
  // ----------------------------------------
  logic [4:0] next_sum;
  logic [3:0] next_acc;
  logic next_carry;
  logic next_skip;
  logic suppress;
  logic [7:0] op;

  assign op = req.opcode;

  // the previous instruction asked to skip: swallow this one entirely
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      suppress <= 1'b0;
    end else if (req.valid) begin
      suppress <= next_skip;
    end
  end

  // one case covers every opcode; unknown ones behave as no-op here
  always_comb begin
    next_sum = 5'h00;
    next_acc = acc;
    next_carry = carry;
    next_skip = 1'b0;
    if (!suppress) begin
      case (op)
        NAU_OP_SUM_WITH_CARRY_SKIP: begin
          next_sum = {1'b0, acc} + {1'b0, mem_data} + {4'h0, carry};
          next_acc = next_sum[3:0];
          next_carry = next_sum[4];
          next_skip = next_sum[4];
        end
        NAU_OP_SUM: begin
          next_sum = {1'b0, acc} + {1'b0, mem_data};
          next_acc = next_sum[3:0];
        end
        NAU_OP_PLUS_TEN: begin
          next_sum = {1'b0, acc} + {1'b0, NAU_TEN};
          next_acc = next_sum[3:0];
        end
        NAU_OP_INVERTED_ACC_CARRY_SUM: begin
          next_sum = {1'b0, ~acc} + {1'b0, mem_data} + {4'h0, carry};
          next_acc = next_sum[3:0];
          next_carry = next_sum[4];
          next_skip = next_sum[4];
        end
        NAU_OP_ZERO_ACC: next_acc = 4'h0;
        NAU_OP_INVERT: next_acc = ~acc;
        NAU_OP_NOP: next_acc = acc;
        NAU_OP_CARRY_ZERO: next_carry = 1'b0;
        NAU_OP_CARRY_ONE: next_carry = 1'b1;
        NAU_OP_XOR: next_acc = acc ^ mem_data;
        default: begin
          // zero immediate is left to other groups, so 50 is not an add
          if (op[7:4] == NAU_OP_IMMEDIATE_SUM_SKIP_HI && op[3:0] != 4'h0) begin
            next_sum = {1'b0, acc} + {1'b0, op[3:0]};
            next_acc = next_sum[3:0];
            next_skip = next_sum[4];
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // architectural registers
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      acc <= NAU_ACC_RESET;
      carry <= NAU_CARRY_RESET;
    end else if (req.valid) begin
      acc <= next_acc;
      carry <= next_carry;
    end
  end

  // registered response so outputs come from flops; one cycle after the request
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      resp <= '0;
    end else begin
      resp.done <= req.valid;
      resp.skip <= req.valid & next_skip;
    end
  end

  // memory address registered from the pointers; mem_data is read by the opcode in the same cycle
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mem_addr <= '0;
    end else begin
      mem_addr <= {ram_row_pointer, ram_digit_pointer};
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_sum_carry;
    @(posedge clk_sys) disable iff (!nrst)
      (req.valid && !suppress && op == NAU_OP_SUM_WITH_CARRY_SKIP) |=>
      ({carry, acc} == $past({1'b0, acc}) + $past({1'b0, mem_data}) + $past({4'h0, carry}))
      && (resp.skip == carry);
  endproperty
  a_sum_carry: assert property (p_sum_carry) else $error("sum with carry wrong");

  property p_sum;
    @(posedge clk_sys) disable iff (!nrst)
      (req.valid && !suppress && op == NAU_OP_SUM) |=>
      (acc == $past(acc) + $past(mem_data)) && $stable(carry) && !resp.skip;
  endproperty
  a_sum: assert property (p_sum) else $error("plain sum wrong");

  property p_ten;
    @(posedge clk_sys) disable iff (!nrst)
      (req.valid && !suppress && op == NAU_OP_PLUS_TEN) |=>
      (acc == $past(acc) + 4'hA) && $stable(carry) && !resp.skip;
  endproperty
  a_ten: assert property (p_ten) else $error("plus ten wrong");

  property p_imm;
    @(posedge clk_sys) disable iff (!nrst)
      (req.valid && !suppress && op[7:4] == 4'h5 && op[3:0] != 4'h0) |=>
      ({resp.skip, acc} == $past({1'b0, acc}) + $past({1'b0, op[3:0]})) && $stable(carry);
  endproperty
  a_imm: assert property (p_imm) else $error("immediate sum wrong");

  property p_inv_sum;
    @(posedge clk_sys) disable iff (!nrst)
      (req.valid && !suppress && op == NAU_OP_INVERTED_ACC_CARRY_SUM) |=>
      ({carry, acc} == $past({1'b0, ~acc}) + $past({1'b0, mem_data}) + $past({4'h0, carry}));
  endproperty
  a_inv_sum: assert property (p_inv_sum) else $error("inverted sum wrong");

  property p_clear;
    @(posedge clk_sys) disable iff (!nrst)
      (req.valid && !suppress && op == NAU_OP_ZERO_ACC) |=> acc == 4'h0 && $stable(carry);
  endproperty
  a_clear: assert property (p_clear) else $error("clear wrong");

  property p_nop;
    @(posedge clk_sys) disable iff (!nrst)
      (req.valid && op == NAU_OP_NOP) |=> $stable(acc) && $stable(carry) && !resp.skip;
  endproperty
  a_nop: assert property (p_nop) else $error("no-op changed state");

  property p_carry_ops;
    @(posedge clk_sys) disable iff (!nrst)
      (req.valid && !suppress && (op == NAU_OP_CARRY_ZERO || op == NAU_OP_CARRY_ONE)) |=>
      carry == ($past(op) == NAU_OP_CARRY_ONE) && !resp.skip;
  endproperty
  a_carry_ops: assert property (p_carry_ops) else $error("carry set or clear wrong");

  property p_skip_next;
    @(posedge clk_sys) disable iff (!nrst)
      (resp.skip ##0 req.valid) |=> $stable(acc) && $stable(carry) && !resp.skip;
  endproperty
  a_skip_next: assert property (p_skip_next) else $error("skipped opcode had effect");

  property p_invert;
    @(posedge clk_sys) disable iff (!nrst)
      (req.valid && !suppress && op == NAU_OP_INVERT) |=>
      (acc == ~$past(acc)) && $stable(carry) && !resp.skip;
  endproperty
  a_invert: assert property (p_invert) else $error("invert wrong");

  property p_xor;
    @(posedge clk_sys) disable iff (!nrst)
      (req.valid && !suppress && op == NAU_OP_XOR) |=>
      (acc == ($past(acc) ^ $past(mem_data))) && $stable(carry) && !resp.skip;
  endproperty
  a_xor: assert property (p_xor) else $error("exclusive-or wrong");

  // a zero immediate must leave accumulator and carry unchanged and raise no skip
  property p_imm_zero;
    @(posedge clk_sys) disable iff (!nrst)
      (req.valid && !suppress && op == {NAU_OP_IMMEDIATE_SUM_SKIP_HI, 4'h0}) |=>
      $stable(acc) && $stable(carry) && !resp.skip;
  endproperty
  a_imm_zero: assert property (p_imm_zero) else $error("zero immediate changed state");

endmodule
`default_nettype wire

/* File: testbench/nau_ram_model.sv */
// nibble data memory model seen by the arithmetic unit
// assumes the unit reads the nibble at the pointers in the request cycle
`timescale 1ns/1ps
`default_nettype none
module nau_ram_model (
  input wire logic [1:0] row,
  input wire logic [3:0] digit,
  output logic [3:0] mem_data
);
  // contents follow the address so expectations need no table
  assign mem_data = digit ^ {2'h0, row};
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
// self-checking bench for the nibble arithmetic unit
// assumes one request every other cycle, except in the back-to-back test;
// the memory model is combinational
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import nau_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  nau_req_type req = '0;
  logic [1:0] row = 2'h0;
  logic [3:0] dig = 4'h0;
  logic [3:0] mem_data;
  logic [5:0] mem_addr;
  logic [3:0] acc;
  logic carry;
  nau_resp_type resp;
  int n_fail = 0;
  int total_checks = 0;
  // ----------------------------------------
  // clock, design and partner
  // ----------------------------------------
  always #12.5 clk_sys = ~clk_sys;
  nau_unit #(.ROW_W(2)) u_nau_unit (.clk_sys(clk_sys), .nrst(nrst), .req(req),
    .ram_row_pointer(row), .ram_digit_pointer(dig), .mem_data(mem_data),
    .mem_addr(mem_addr), .acc(acc), .carry(carry), .resp(resp));
  nau_ram_model u_nau_ram_model (.row(row), .digit(dig), .mem_data(mem_data));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one request, then judge the registered answer a cycle later
  task automatic op(input logic [7:0] o, input logic [3:0] d, input logic [3:0] ea,
    input logic ec, input logic es);
    @(negedge clk_sys);
    req = '{1'b1, o};
    dig = d;
    @(negedge clk_sys);
    req.valid = 1'b0;
    chk("acc", {4'h0, acc}, {4'h0, ea});
    chk("carry", {7'h0, carry}, {7'h0, ec});
    chk("skip", {7'h0, resp.skip}, {7'h0, es});
    chk("done", {7'h0, resp.done}, 8'h01);
    chk("addr", {2'h0, mem_addr}, {2'h0, row, d});
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_arith;
    op(8'h31, 4'hF, 4'hF, 1'b0, 1'b0);
    op(8'h30, 4'h1, 4'h0, 1'b1, 1'b1);
    op(8'h31, 4'h5, 4'h0, 1'b1, 1'b0);
    op(8'h30, 4'h2, 4'h3, 1'b0, 1'b0);
    op(8'h4A, 4'h0, 4'hD, 1'b0, 1'b0);
    op(8'h4A, 4'h0, 4'h7, 1'b0, 1'b0);
    op(8'h5F, 4'h0, 4'h6, 1'b0, 1'b1);
    op(8'h22, 4'h0, 4'h6, 1'b0, 1'b0);
    op(8'h53, 4'h0, 4'h9, 1'b0, 1'b0);
    op(8'h10, 4'h4, 4'hA, 1'b0, 1'b0);
    op(8'h22, 4'h0, 4'hA, 1'b1, 1'b0);
    op(8'h10, 4'h9, 4'hF, 1'b0, 1'b0);
    op(8'h22, 4'h0, 4'hF, 1'b1, 1'b0);
    op(8'h10, 4'hF, 4'h0, 1'b1, 1'b1);
    op(8'h40, 4'h0, 4'h0, 1'b1, 1'b0);
    $display("t_arith done");
  endtask
  // row moves to 1 so the memory nibble is digit xor 1
  task automatic t_logic;
    row = 2'h1;
    op(8'h40, 4'h0, 4'hF, 1'b1, 1'b0);
    op(8'h02, 4'h7, 4'h9, 1'b1, 1'b0);
    op(8'h44, 4'h3, 4'h9, 1'b1, 1'b0);
    op(8'h32, 4'h0, 4'h9, 1'b0, 1'b0);
    op(8'h50, 4'h0, 4'h9, 1'b0, 1'b0);
    op(8'h00, 4'h0, 4'h0, 1'b0, 1'b0);
    $display("t_logic done");
  endtask
  // back-to-back requests: the one right after a skipping add must do nothing
  task automatic t_back_to_back;
    op(8'h40, 4'h0, 4'hF, 1'b0, 1'b0);
    @(negedge clk_sys);
    req = '{1'b1, 8'h51};
    @(negedge clk_sys);
    chk("b2b_acc", {4'h0, acc}, 8'h00);
    chk("b2b_carry", {7'h0, carry}, 8'h00);
    chk("b2b_skip", {7'h0, resp.skip}, 8'h01);
    req = '{1'b1, NAU_OP_INVERT};
    @(negedge clk_sys);
    req.valid = 1'b0;
    chk("void_acc", {4'h0, acc}, 8'h00);
    chk("void_skip", {7'h0, resp.skip}, 8'h00);
    chk("void_done", {7'h0, resp.done}, 8'h01);
    op(8'h40, 4'h0, 4'hF, 1'b0, 1'b0);
    $display("t_back_to_back done");
  endtask
  // reset in mid-run with a skip pending: the pending skip must not survive it
  task automatic t_reset;
    @(negedge clk_sys);
    req = '{1'b1, 8'h5F};
    @(negedge clk_sys);
    req.valid = 1'b0;
    nrst = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk("acc_mid_rst", {4'h0, acc}, {4'h0, NAU_ACC_RESET});
    chk("carry_mid_rst", {7'h0, carry}, {7'h0, NAU_CARRY_RESET});
    chk("resp_mid_rst", {6'h00, resp}, 8'h00);
    chk("addr_mid_rst", {2'h0, mem_addr}, 8'h00);
    nrst = 1'b1;
    op(8'h31, 4'h4, 4'h5, 1'b0, 1'b0);
    $display("t_reset done");
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (20) @(negedge clk_sys);
    chk("acc_rst", {4'h0, acc}, {4'h0, NAU_ACC_RESET});
    chk("carry_rst", {7'h0, carry}, {7'h0, NAU_CARRY_RESET});
    nrst = 1'b1;
    t_arith();
    t_logic();
    t_back_to_back();
    t_reset();
    end_sim();
  end
  // the tests need about seventy-five cycles, so two thousand is ample
  initial begin
    #50000;
    n_fail++;
    end_sim();
  end
endmodule
`default_nettype wire
